// *** gxe_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module gxe_port (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] port_pin_in,
    output logic [7:0] port_pin_out,
    output logic [7:0] port_pin_oe,
    input wire logic edge_irq_pin,
    output logic host_irq_n
);
    import gxe_pkg::*;

    logic [7:0] port_mode_low;
    logic [7:0] port_mode_high;
    logic [7:0] port_level;
    logic edge_irq_flag;
    logic edge_irq_enable;
    logic edge_polarity_sel;
    logic [7:0] next_mode_low;
    logic [7:0] next_mode_high;
    logic [7:0] next_level;
    logic next_flag;
    logic next_enable;
    logic next_polarity;
    logic [7:0] next_rdata;
    logic [7:0] next_pin_out;
    logic [7:0] next_pin_oe;
    logic next_irq_n;
    logic [7:0] pin_sync;
    logic [15:0] mode_all;

    gxe_edge_if edge_link ();

    gxe_pin_sync u_pin_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .pin_raw(port_pin_in),
        .pin_sync(pin_sync)
    );

    gxe_edge_det u_edge_det (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .edge_irq_pin(edge_irq_pin),
        .edge_link(edge_link)
    );

    assign edge_link.enable = edge_irq_enable;
    assign edge_link.polarity = edge_polarity_sel;
    assign mode_all = {port_mode_high, port_mode_low};

    // Per-pin drive: returns {oe, out}
    function automatic logic [1:0] pin_drive(input logic [1:0] mode, input logic level);
        logic [1:0] res;
        res = 2'b00;
        case (mode)
            GXE_MODE_OPEN_DRAIN: res = {!level, 1'b0};
            GXE_MODE_PUSH_PULL: res = {1'b1, level};
            default: res = 2'b00;
        endcase
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Register file
    always_comb begin
        next_mode_low = port_mode_low;
        next_mode_high = port_mode_high;
        next_level = port_level;
        next_enable = edge_irq_enable;
        next_polarity = edge_polarity_sel;
        next_flag = edge_irq_flag;
        next_rdata = reg_rdata;
        if (reg_wr) begin
            if (reg_addr == GXE_ADDR_MODE_LOW) begin
                next_mode_low = reg_wdata;
            end else if (reg_addr == GXE_ADDR_LEVEL) begin
                next_level = reg_wdata;
            end else if (reg_addr == GXE_ADDR_MODE_HIGH) begin
                next_mode_high = reg_wdata;
            end else if (reg_addr == GXE_ADDR_EDGE_CTRL) begin
                next_enable = reg_wdata[GXE_BIT_ENABLE];
                next_polarity = reg_wdata[GXE_BIT_POLARITY];
            end
        end
        if (reg_rd) begin
            if (reg_addr == GXE_ADDR_MODE_LOW) begin
                next_rdata = port_mode_low;
            end else if (reg_addr == GXE_ADDR_LEVEL) begin
                next_rdata = pin_sync;
            end else if (reg_addr == GXE_ADDR_MODE_HIGH) begin
                next_rdata = port_mode_high;
            end else if (reg_addr == GXE_ADDR_EDGE_CTRL) begin
                next_rdata = {edge_irq_flag, edge_irq_enable, edge_polarity_sel, 5'h00};
                next_flag = 1'b0;
            end else begin
                next_rdata = 8'h00;
            end
        end
        // A new edge wins over a clearing read so it is never lost
        if (edge_link.edge_event) begin
            next_flag = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_mode_low <= GXE_RST_MODE_LOW;
            port_mode_high <= GXE_RST_MODE_HIGH;
            port_level <= GXE_RST_LEVEL;
            edge_irq_flag <= GXE_RST_EDGE_CTRL[GXE_BIT_FLAG];
            edge_irq_enable <= GXE_RST_EDGE_CTRL[GXE_BIT_ENABLE];
            edge_polarity_sel <= GXE_RST_EDGE_CTRL[GXE_BIT_POLARITY];
            reg_rdata <= 8'h00;
        end else begin
            port_mode_low <= next_mode_low;
            port_mode_high <= next_mode_high;
            port_level <= next_level;
            edge_irq_flag <= next_flag;
            edge_irq_enable <= next_enable;
            edge_polarity_sel <= next_polarity;
            reg_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin drivers and interrupt line, registered
    always_comb begin
        logic [1:0] drv;
        drv = 2'b00;
        next_pin_out = 8'h00;
        next_pin_oe = 8'h00;
        for (int i = 0; i < GXE_PIN_COUNT; i++) begin
            drv = pin_drive(mode_all[i*GXE_MODE_W +: GXE_MODE_W], next_level[i]);
            next_pin_oe[i] = drv[1];
            next_pin_out[i] = drv[0];
        end
        next_irq_n = !next_flag;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_pin_out <= 8'h00;
            port_pin_oe <= 8'h00;
            host_irq_n <= 1'b1;
        end else begin
            port_pin_out <= next_pin_out;
            port_pin_oe <= next_pin_oe;
            host_irq_n <= next_irq_n;
        end
    end

    ////////////////////////////////////////////////////////////////////
    sequence s_edge_seen;
        edge_link.edge_event;
    endsequence

    sequence s_flag_up_irq_low;
        edge_irq_flag && !host_irq_n;
    endsequence

    property p_edge_sets_irq;
        @(posedge core_clk) disable iff (sys_rst)
        s_edge_seen |=> s_flag_up_irq_low;
    endproperty
    a_edge_sets_irq: assert property (p_edge_sets_irq) else $error("no irq");

    property p_read_clears;
        @(posedge core_clk) disable iff (sys_rst)
        (reg_rd && reg_addr == GXE_ADDR_EDGE_CTRL && !edge_link.edge_event)
            |=> !edge_irq_flag && host_irq_n;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("flag kept");

    property p_irq_holds;
        @(posedge core_clk) disable iff (sys_rst)
        (edge_irq_flag && !(reg_rd && reg_addr == GXE_ADDR_EDGE_CTRL)) |=> edge_irq_flag;
    endproperty
    a_irq_holds: assert property (p_irq_holds) else $error("flag dropped without read");

    property p_level_read;
        @(posedge core_clk) disable iff (sys_rst)
        (reg_rd && reg_addr == GXE_ADDR_LEVEL) |=> reg_rdata == $past(pin_sync);
    endproperty
    a_level_read: assert property (p_level_read) else $error("level read wrong");

    property p_push_pull;
        @(posedge core_clk) disable iff (sys_rst)
        (port_mode_low[1:0] == GXE_MODE_PUSH_PULL && !reg_wr)
            |=> port_pin_oe[0] && port_pin_out[0] == $past(port_level[0]);
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("push-pull pin 0 wrong");

    property p_reserved_input;
        @(posedge core_clk) disable iff (sys_rst)
        (port_mode_high[7:6] == GXE_MODE_RESERVED && !reg_wr) |=> !port_pin_oe[7];
    endproperty
    a_reserved_input: assert property (p_reserved_input) else $error("reserved on");

    property p_open_drain;
        @(posedge core_clk) disable iff (sys_rst)
        (port_mode_low[7:6] == GXE_MODE_OPEN_DRAIN && !reg_wr)
            |=> !port_pin_out[3] && port_pin_oe[3] == !$past(port_level[3]);
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open-drain pin 3 wrong");

    property p_level_write;
        @(posedge core_clk) disable iff (sys_rst)
        (reg_wr && reg_addr == GXE_ADDR_LEVEL) |=> port_level == $past(reg_wdata);
    endproperty
    a_level_write: assert property (p_level_write) else $error("level write lost");

    property p_high_mode_write;
        @(posedge core_clk) disable iff (sys_rst)
        (reg_wr && reg_addr == GXE_ADDR_MODE_HIGH) |=> port_mode_high == $past(reg_wdata);
    endproperty
    a_high_mode_write: assert property (p_high_mode_write) else $error("mode hi lost");

    property p_ctrl_read_layout;
        @(posedge core_clk) disable iff (sys_rst)
        (reg_rd && reg_addr == GXE_ADDR_EDGE_CTRL) |=> reg_rdata[4:0] == 5'h00
            && reg_rdata[6] == $past(edge_irq_enable);
    endproperty
    a_ctrl_read_layout: assert property (p_ctrl_read_layout) else $error("ctrl layout");

    property p_low_mode_write;
        @(posedge core_clk) disable iff (sys_rst)
        (reg_wr && reg_addr == GXE_ADDR_MODE_LOW) |=> port_mode_low == $past(reg_wdata);
    endproperty
    a_low_mode_write: assert property (p_low_mode_write) else $error("mode lo lost");

    property p_input_only;
        @(posedge core_clk) disable iff (sys_rst)
        (port_mode_low[3:2] == GXE_MODE_INPUT) |=> !port_pin_oe[1] && !port_pin_out[1];
    endproperty
    a_input_only: assert property (p_input_only) else $error("input drives");

    property p_ctrl_write;
        @(posedge core_clk) disable iff (sys_rst)
        (reg_wr && reg_addr == GXE_ADDR_EDGE_CTRL)
            |=> edge_irq_enable == $past(reg_wdata[GXE_BIT_ENABLE])
            && edge_polarity_sel == $past(reg_wdata[GXE_BIT_POLARITY]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("ctrl write lost");

    property p_ctrl_fields;
        @(posedge core_clk) disable iff (sys_rst)
        (reg_rd && reg_addr == GXE_ADDR_EDGE_CTRL)
            |=> reg_rdata[GXE_BIT_FLAG] == $past(edge_irq_flag)
            && reg_rdata[GXE_BIT_POLARITY] == $past(edge_polarity_sel);
    endproperty
    a_ctrl_fields: assert property (p_ctrl_fields) else $error("ctrl fields wrong");

    property p_flag_needs_edge;
        @(posedge core_clk) disable iff (sys_rst)
        (!edge_irq_flag && !edge_link.edge_event) |=> !edge_irq_flag;
    endproperty
    a_flag_needs_edge: assert property (p_flag_needs_edge) else $error("flag rose");

    property p_irq_tracks_flag;
        @(posedge core_clk) disable iff (sys_rst)
        edge_irq_flag |-> !host_irq_n;
    endproperty
    a_irq_tracks_flag: assert property (p_irq_tracks_flag) else $error("irq off");

    property p_open_drain_high;
        @(posedge core_clk) disable iff (sys_rst)
        (port_mode_high[1:0] == GXE_MODE_OPEN_DRAIN && !reg_wr)
            |=> !port_pin_out[4] && port_pin_oe[4] == !$past(port_level[4]);
    endproperty
    a_open_drain_high: assert property (p_open_drain_high) else $error("od pin 4 wrong");

    property p_push_pull_high;
        @(posedge core_clk) disable iff (sys_rst)
        (port_mode_high[7:6] == GXE_MODE_PUSH_PULL && !reg_wr)
            |=> port_pin_oe[7] && port_pin_out[7] == $past(port_level[7]);
    endproperty
    a_push_pull_high: assert property (p_push_pull_high) else $error("pp pin 7 wrong");

    property p_level_pins;
        @(posedge core_clk) disable iff (sys_rst)
        (reg_wr && reg_addr == GXE_ADDR_LEVEL && port_mode_low[1:0] == GXE_MODE_PUSH_PULL)
            |=> port_pin_out[0] == $past(reg_wdata[0]);
    endproperty
    a_level_pins: assert property (p_level_pins) else $error("pin 0 level lost");
endmodule
`default_nettype wire

// *** gxe_pkg.sv ***
package gxe_pkg;
    // Internal register addresses
    localparam logic [7:0] GXE_ADDR_MODE_LOW = 8'h00;
    localparam logic [7:0] GXE_ADDR_LEVEL = 8'h01;
    localparam logic [7:0] GXE_ADDR_MODE_HIGH = 8'h07;
    localparam logic [7:0] GXE_ADDR_EDGE_CTRL = 8'h08;
    // Reset values
    localparam logic [7:0] GXE_RST_MODE_LOW = 8'h00;
    localparam logic [7:0] GXE_RST_MODE_HIGH = 8'h00;
    localparam logic [7:0] GXE_RST_LEVEL = 8'h00;
    localparam logic [7:0] GXE_RST_EDGE_CTRL = 8'h00;
    // Edge control field positions
    localparam int GXE_BIT_FLAG = 7;
    localparam int GXE_BIT_ENABLE = 6;
    localparam int GXE_BIT_POLARITY = 5;
    localparam int GXE_PIN_COUNT = 8;
    localparam int GXE_MODE_W = 2;

    typedef enum logic [1:0] {
        GXE_MODE_OPEN_DRAIN = 2'b00,
        GXE_MODE_INPUT = 2'b01,
        GXE_MODE_PUSH_PULL = 2'b10,
        GXE_MODE_RESERVED = 2'b11
    } gxe_mode_t;
endpackage

// *** gxe_edge_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Edge detector link: control to detector, event back
interface gxe_edge_if;
    logic enable;
    logic polarity;
    logic edge_event;
    modport ctrl (output enable, output polarity, input edge_event);
    modport det (input enable, input polarity, output edge_event);
endinterface
`default_nettype wire

// *** gxe_edge_det.sv ***
`timescale 1ns/1ps
`default_nettype none
module gxe_edge_det (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic edge_irq_pin,
    gxe_edge_if.det edge_link
);
    import gxe_pkg::*;

    logic sync1;
    logic sync2;
    logic prev;
    logic next_sync1;
    logic next_sync2;
    logic next_prev;
    logic next_event;
    logic edge_event;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        next_sync1 = edge_irq_pin;
        next_sync2 = sync1;
        next_prev = sync2;
        // Polarity 0 catches rising, 1 catches falling
        if (edge_link.polarity) begin
            next_event = edge_link.enable && prev && !sync2;
        end else begin
            next_event = edge_link.enable && !prev && sync2;
        end
    end

    // Two stages before the detector sees the pin
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev <= 1'b0;
            edge_event <= 1'b0;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            prev <= next_prev;
            edge_event <= next_event;
        end
    end

    assign edge_link.edge_event = edge_event;

    ////////////////////////////////////////////////////////////////////
    property p_rise_event;
        @(posedge core_clk) disable iff (sys_rst)
        (edge_link.enable && !edge_link.polarity && !prev && sync2) |=> edge_event;
    endproperty
    a_rise_event: assert property (p_rise_event) else $error("rising edge missed");

    property p_fall_event;
        @(posedge core_clk) disable iff (sys_rst)
        (edge_link.enable && edge_link.polarity && prev && !sync2) |=> edge_event;
    endproperty
    a_fall_event: assert property (p_fall_event) else $error("falling edge missed");

    property p_disabled_quiet;
        @(posedge core_clk) disable iff (sys_rst)
        !edge_link.enable |=> !edge_event;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("event when off");
endmodule
`default_nettype wire

// *** gxe_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// Two flip-flop synchroniser for the port pin levels
module gxe_pin_sync (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] pin_raw,
    output logic [7:0] pin_sync
);
    import gxe_pkg::*;

    logic [7:0] stage1;
    logic [7:0] stage2;
    logic [7:0] next_stage1;
    logic [7:0] next_stage2;

    always_comb begin
        next_stage1 = pin_raw;
        next_stage2 = stage1;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1 <= 8'h00;
            stage2 <= 8'h00;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign pin_sync = stage2;
endmodule
`default_nettype wire

// *** gxe_pin_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// External side of the eight port pins: board pull-ups plus an optional foreign driver
module gxe_pin_partner (
    input wire logic [7:0] port_pin_out,
    input wire logic [7:0] port_pin_oe,
    input wire logic [7:0] ext_oe,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_level
);
    // The device driver wins; a released line takes the foreign driver if it is on, else floats up to the pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_level[i] = port_pin_oe[i] ? port_pin_out[i] : (ext_oe[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule
`default_nettype wire

// *** test_gpio_expander_edge_irq.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_gpio_expander_edge_irq;
    import gxe_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic edge_irq_pin = 1'b0;
    logic [7:0] ext_oe = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] reg_rdata;
    logic [7:0] port_pin_out;
    logic [7:0] port_pin_oe;
    logic [7:0] pin_level;
    logic host_irq_n;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    int m_lo = 0;
    int m_hi = 0;
    int m_lvl = 0;
    int m_ctrl = 0;
    logic [31:0] seed = 32'h727F6659;
    logic [7:0] addrs [5] = '{8'h00, 8'h01, 8'h07, 8'h08, 8'h05};

    always #10 core_clk = ~core_clk;

    gxe_port uut (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .port_pin_in(pin_level), .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
        .edge_irq_pin(edge_irq_pin), .host_irq_n(host_irq_n)
    );
    gxe_pin_partner pins (
        .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe), .ext_oe(ext_oe),
        .ext_val(ext_val), .pin_level(pin_level)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
    endfunction

    // Kind 0 gives enables, 1 output values, 2 the resolved pin levels
    function automatic logic [7:0] exp_port(input int kind);
        logic [7:0] r;
        logic [1:0] md;
        logic oe;
        logic o;
        for (int i = 0; i < 8; i++) begin
            md = i < 4 ? 2'(m_lo >> (2 * i)) : 2'(m_hi >> (2 * (i - 4)));
            oe = (md == 2'b00 && !m_lvl[i]) || md == 2'b10;
            o = (md == 2'b10) && m_lvl[i];
            r[i] = kind == 0 ? oe : kind == 1 ? o : (oe ? o : (ext_oe[i] ? ext_val[i] : 1'b1));
        end
        return r;
    endfunction

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
        case (a)
            GXE_ADDR_MODE_LOW: m_lo = d;
            GXE_ADDR_MODE_HIGH: m_hi = d;
            GXE_ADDR_LEVEL: m_lvl = d;
            GXE_ADDR_EDGE_CTRL: m_ctrl = (m_ctrl & 8'h80) | (d & 8'h60);
            default: ;
        endcase
    endtask

    // Reads and compares one register; a read of edge control also clears the model flag
    task automatic rd_chk(input logic [7:0] a);
        logic [7:0] e;
        case (a)
            GXE_ADDR_MODE_LOW: e = 8'(m_lo);
            GXE_ADDR_MODE_HIGH: e = 8'(m_hi);
            GXE_ADDR_LEVEL: e = exp_port(2);
            GXE_ADDR_EDGE_CTRL: e = 8'(m_ctrl);
            default: e = 8'h00;
        endcase
        @(negedge core_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge core_clk);
        reg_rd = 1'b0;
        cmp_byte(reg_rdata, e);
        if (a == GXE_ADDR_EDGE_CTRL) begin
            m_ctrl = m_ctrl & 8'h7F;
        end
    endtask

    // Moves the interrupt pin and waits out the synchroniser and flag stages
    task automatic set_irq_pin(input logic v);
        logic old;
        old = edge_irq_pin;
        @(negedge core_clk);
        edge_irq_pin = v;
        if (m_ctrl[6] && (m_ctrl[5] ? (old && !v) : (!old && v))) begin
            m_ctrl = m_ctrl | 8'h80;
        end
        repeat (6) @(negedge core_clk);
    endtask

    task automatic finish_test();
        $display("comparisons %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // A hang of the test must not stall the run forever
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge core_clk);
        sys_rst = 1'b0;
        @(negedge core_clk);
        cmp_byte(port_pin_oe, exp_port(0));
        foreach (addrs[k]) begin
            rd_chk(addrs[k]);
        end
        for (int n = 0; n < 24; n++) begin
            seed = lfsr(seed);
            ext_val = seed[31:24];
            ext_oe = seed[23:16];
            wr(GXE_ADDR_MODE_LOW, seed[7:0]);
            wr(GXE_ADDR_LEVEL, seed[15:8]);
            seed = lfsr(seed);
            wr(GXE_ADDR_MODE_HIGH, seed[7:0]);
            // A mode write reaches the pin drivers one cycle after the register
            @(negedge core_clk);
            cmp_byte(port_pin_oe, exp_port(0));
            cmp_byte(port_pin_out, exp_port(1));
            repeat (3) @(negedge core_clk);
            rd_chk(GXE_ADDR_LEVEL);
            rd_chk(GXE_ADDR_MODE_LOW);
            rd_chk(GXE_ADDR_MODE_HIGH);
        end
        ext_oe = 8'h00;
        wr(GXE_ADDR_EDGE_CTRL, 8'hBF);
        rd_chk(GXE_ADDR_EDGE_CTRL);
        set_irq_pin(1'b1);
        set_irq_pin(1'b0);
        cmp_bit(host_irq_n, 1'b1);
        rd_chk(GXE_ADDR_EDGE_CTRL);
        for (int p = 0; p < 2; p++) begin
            set_irq_pin(p == 0);
            wr(GXE_ADDR_EDGE_CTRL, p == 1 ? 8'h60 : 8'h40);
            set_irq_pin(p == 1);
            cmp_bit(host_irq_n, 1'b1);
            set_irq_pin(p == 0);
            cmp_bit(host_irq_n, 1'b0);
            repeat (10) @(negedge core_clk);
            cmp_bit(host_irq_n, 1'b0);
            rd_chk(GXE_ADDR_EDGE_CTRL);
            repeat (2) @(negedge core_clk);
            cmp_bit(host_irq_n, 1'b1);
            rd_chk(GXE_ADDR_EDGE_CTRL);
        end
        finish_test();
    end
endmodule
`default_nettype wire
